// ==== design/odsc_serial_ctrl.sv ====
// Functional notes
// - external reset low keeps the device asleep, logic idle, drivers off
// - chip select falling loads output status and drives serial output
// - each rising shift clock while selected presents next bit, bit 7 first
// - serial input sampled on falling shift clock; host changes it elsewhere
// - chip select rising copies shift register into output latches
// - serial output high impedance while chip select is high and test mode 1 is off
// - latched 0 turns driver on, latched 1 leaves it off
// - in a chain each device loads its output status on select falling
// - power-up sets latches to all ones and clears timers, all outputs off
// - power-on reset and external reset each alone reset the device
// - in external reset serial output low while selected, else high impedance
// - external reset acts only after the minimum pulse width
// - continuous current limiting for about 40 ms disables that output
// - after a disable the timer clears; host may re-enable output
// - persistent short limits again and disables after another 40 ms
// - shifted-out bits reflect actual pin state of each output
// - no fault status bit; faults found by comparing readback
// - open load commanded off reads back 0 through the pin pull-down
// - over-temperature disables all drivers, keeps latches, reads all ones
// - latches restored after over-temperature unless newer data arrived
// - test mode 1 shortens counter chain and shows oscillator/2 on output
// - short-circuit disable sets that channel latch bit to off
`timescale 1ns/1ps
module odsc_serial_ctrl
	import odsc_pkg::*;
#(
	parameter int CH            = NUM_CH,
	parameter int RST_PULSE_CYC = MIN_RST_PULSE_CYC,
	parameter int OSC_DIV       = OSC_DIV_CYC,
	parameter int SC_TICKS      = SC_LIMIT_TICKS,
	parameter int TEST_SHIFT    = TEST_SHORT_STAGES
) (
	input  wire logic          ref_clk,
	input  wire logic          sys_rst,
	input  wire logic          chipEnableN,
	input  wire logic          shiftClk,
	input  wire logic          serIn,
	input  wire logic          extRstN,
	input  wire logic          testMode1,
	input  wire logic          overTemp,
	input  wire logic [CH-1:0] currentLimit,
	input  wire logic [CH-1:0] driverPin,
	output logic               serOut,
	output logic               serOutOeN,
	output logic      [CH-1:0] driverOff,
	output logic               sleepMode
);

	if (CH != NUM_CH) begin : g_bad_ch
		$error("odsc_serial_ctrl: CH must match the packed pin layout");
	end
	if (RST_PULSE_CYC < 1 || OSC_DIV < 2 || SC_TICKS < 2) begin : g_bad_time
		$error("odsc_serial_ctrl: timing parameters out of range");
	end
	if (TEST_SHIFT < 0 || (SC_TICKS >> TEST_SHIFT) < 1) begin : g_bad_shift
		$error("odsc_serial_ctrl: TEST_SHIFT too large");
	end

	localparam int RW = $clog2(RST_PULSE_CYC + 1);
	localparam int OW = $clog2(OSC_DIV);
	localparam int SW = $clog2(SC_TICKS + 1);
	localparam logic [RW-1:0] RST_LIMIT  = RW'(RST_PULSE_CYC);
	localparam logic [OW-1:0] OSC_LAST   = OW'(OSC_DIV - 1);
	localparam logic [SW-1:0] SC_FULL    = SW'(SC_TICKS);
	localparam logic [SW-1:0] SC_SHORT   = SW'(SC_TICKS >> TEST_SHIFT);

	//////////////////////////////////////////////////////////////////////////
	// input synchronisers: three stages, change accepted when last two agree
	odsc_pins_t        pinRaw;
	odsc_pins_t        pinF;
	logic [PIN_BITS-1:0] syncQ [SYNC_STAGES];
	logic [PIN_BITS-1:0] filtQ;
	// reset to idle levels keeps edge detectors and test mode quiet after reset
	localparam logic [PIN_BITS-1:0] PIN_IDLE_BITS = PIN_IDLE;

	assign pinRaw.ceN       = chipEnableN;
	assign pinRaw.sclk      = shiftClk;
	assign pinRaw.si        = serIn;
	assign pinRaw.rstN      = extRstN;
	assign pinRaw.testMode  = testMode1;
	assign pinRaw.overTemp  = overTemp;
	assign pinRaw.curLimit  = currentLimit;
	assign pinRaw.driverPin = driverPin;
	assign pinF             = odsc_pins_t'(filtQ);

	genvar gb;
	generate
		for (gb = 0; gb < PIN_BITS; gb++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					syncQ[0][gb] <= PIN_IDLE_BITS[gb];
					syncQ[1][gb] <= PIN_IDLE_BITS[gb];
					syncQ[2][gb] <= PIN_IDLE_BITS[gb];
					filtQ[gb]    <= PIN_IDLE_BITS[gb];
				end else begin
					syncQ[0][gb] <= pinRaw[gb];
					syncQ[1][gb] <= syncQ[0][gb];
					syncQ[2][gb] <= syncQ[1][gb];
					if (syncQ[1][gb] == syncQ[2][gb])
						filtQ[gb] <= syncQ[2][gb];
				end
			end
		end
	endgenerate

	logic ceNPrevQ;
	logic sclkPrevQ;
	logic ceFall;
	logic ceRise;
	logic sclkRise;
	logic sclkFall;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ceNPrevQ  <= 1'b1;
			sclkPrevQ <= 1'b0;
		end else begin
			ceNPrevQ  <= pinF.ceN;
			sclkPrevQ <= pinF.sclk;
		end
	end

	assign ceFall   = ceNPrevQ && !pinF.ceN;
	assign ceRise   = !ceNPrevQ && pinF.ceN;
	assign sclkRise = !sclkPrevQ && pinF.sclk;
	assign sclkFall = sclkPrevQ && !pinF.sclk;

	//////////////////////////////////////////////////////////////////////////
	// external reset pulse filter
	logic [RW-1:0] rstCntQ;
	logic          extRstQ;
	logic          rstAll;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rstCntQ <= '0;
			extRstQ <= 1'b0;
		end else if (pinF.rstN) begin
			rstCntQ <= '0;
			extRstQ <= 1'b0;
		end else if (rstCntQ != RST_LIMIT) begin
			rstCntQ <= rstCntQ + RW'(1);
		end else begin
			extRstQ <= 1'b1;
		end
	end

	assign rstAll = sys_rst || extRstQ;

	//////////////////////////////////////////////////////////////////////////
	// frame state
	odsc_state_t stateQ;
	odsc_state_t stateD;

	always_comb begin
		stateD = stateQ;
		case (stateQ)
			ST_SLEEP: begin
				if (!rstAll)
					stateD = ST_IDLE;
			end
			ST_IDLE: begin
				if (rstAll)
					stateD = ST_SLEEP;
				else if (ceFall)
					stateD = ST_SEL;
			end
			ST_SEL: begin
				if (rstAll)
					stateD = ST_SLEEP;
				else if (ceRise)
					stateD = ST_IDLE;
			end
			default: stateD = ST_SLEEP;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			stateQ <= ST_SLEEP;
		else
			stateQ <= stateD;
	end

	//////////////////////////////////////////////////////////////////////////
	// internal oscillator ticks and test mode toggle
	logic [OW-1:0] oscCntQ;
	logic          oscTick;
	logic          oscHalfQ;

	assign oscTick = (oscCntQ == OSC_LAST);

	always_ff @(posedge ref_clk) begin
		if (rstAll) begin
			oscCntQ  <= '0;
			oscHalfQ <= 1'b0;
		end else if (oscTick) begin
			oscCntQ  <= '0;
			oscHalfQ <= ~oscHalfQ;
		end else begin
			oscCntQ <= oscCntQ + OW'(1);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// short-circuit timers, one per output
	logic [CH-1:0] latchQ;
	logic [CH-1:0] scFire;
	logic [SW-1:0] scLimit;

	assign scLimit = pinF.testMode ? SC_SHORT : SC_FULL;

	genvar gc;
	generate
		for (gc = 0; gc < CH; gc++) begin : g_sc
			logic [SW-1:0] scCntQ;

			assign scFire[gc] = (scCntQ >= scLimit);

			always_ff @(posedge ref_clk) begin
				if (rstAll)
					scCntQ <= '0;
				else if (!pinF.curLimit[gc] || latchQ[gc] || scFire[gc])
					scCntQ <= '0;
				else if (oscTick)
					scCntQ <= scCntQ + SW'(1);
			end
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// shift register
	logic [CH-1:0] shiftQ;
	logic [CH-1:0] readBack;
	logic          selected;

	assign selected = (stateQ == ST_SEL);
	// pin level is the status; pull-down makes an open load read 0
	assign readBack = pinF.overTemp ? READ_SHUTDOWN : pinF.driverPin;

	always_ff @(posedge ref_clk) begin
		if (rstAll)
			shiftQ <= '0;
		else if (stateQ == ST_IDLE && ceFall)
			shiftQ <= readBack;
		else if (selected && sclkFall)
			shiftQ <= {shiftQ[CH-2:0], pinF.si};
	end

	//////////////////////////////////////////////////////////////////////////
	// frame word handed to the latches through the two-entry buffer
	logic          pendValidQ;
	logic [CH-1:0] pendDataQ;
	logic          bufInReady;
	logic          bufOutValid;
	logic          bufOutReady;
	logic [CH-1:0] bufOutData;

	always_ff @(posedge ref_clk) begin
		if (rstAll) begin
			pendValidQ <= 1'b0;
			pendDataQ  <= '0;
		end else if (selected && ceRise) begin
			pendValidQ <= 1'b1;
			pendDataQ  <= shiftQ;
		end else if (bufInReady) begin
			pendValidQ <= 1'b0;
		end
	end

	// latches take no frame word in a cycle where a timer disables a channel
	assign bufOutReady = !(|scFire);

	odsc_pair_buffer #(
		.WIDTH (CH),
		.DEPTH (2)
	) u_buf (
		.ref_clk  (ref_clk),
		.sys_rst  (rstAll),
		.inValid  (pendValidQ),
		.inReady  (bufInReady),
		.inData   (pendDataQ),
		.outValid (bufOutValid),
		.outReady (bufOutReady),
		.outData  (bufOutData)
	);

	//////////////////////////////////////////////////////////////////////////
	// output latches
	always_ff @(posedge ref_clk) begin
		if (rstAll)
			latchQ <= LATCH_RESET;
		else if (|scFire)
			latchQ <= latchQ | scFire;
		else if (bufOutValid)
			latchQ <= bufOutData;
	end

	//////////////////////////////////////////////////////////////////////////
	// driver gates
	always_ff @(posedge ref_clk) begin
		if (rstAll)
			driverOff <= LATCH_RESET;
		else if (pinF.overTemp)
			driverOff <= LATCH_RESET;
		else
			driverOff <= latchQ;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			sleepMode <= 1'b1;
		else
			sleepMode <= extRstQ;
	end

	//////////////////////////////////////////////////////////////////////////
	// serial output
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			serOut    <= 1'b0;
			serOutOeN <= 1'b1;
		end else if (pinF.testMode && !extRstQ) begin
			serOut    <= oscHalfQ;
			serOutOeN <= 1'b0;
		end else if (extRstQ) begin
			serOut    <= 1'b0;
			serOutOeN <= pinF.ceN;
		end else if (pinF.ceN) begin
			serOut    <= 1'b0;
			serOutOeN <= 1'b1;
		end else begin
			serOutOeN <= 1'b0;
			if (selected && sclkRise)
				serOut <= shiftQ[FIRST_SHIFTED_BIT];
		end
	end

endmodule

// ==== design/odsc_pkg.sv ====
package odsc_pkg;

	localparam int NUM_CH            = 8;
	localparam int CLK_PERIOD_PS     = 5000;
	// reset pulse must be longer than this before it acts
	localparam int MIN_RST_PULSE_NS  = 310000;
	localparam int MIN_RST_PULSE_CYC = (MIN_RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
	                                   / CLK_PERIOD_PS;
	// internal rc oscillator period, modelled by a divider
	localparam int OSC_PERIOD_NS     = 1000;
	localparam int OSC_DIV_CYC       = (OSC_PERIOD_NS * 1000) / CLK_PERIOD_PS;
	// short-circuit current limit duration before disable
	localparam int SC_LIMIT_MS       = 40;
	localparam int SC_LIMIT_TICKS    = (SC_LIMIT_MS * 1000000) / OSC_PERIOD_NS;
	// test mode 1 shortens the counter chain by this many stages
	localparam int TEST_SHORT_STAGES = 6;
	localparam int SYNC_STAGES       = 3;
	localparam int FIRST_SHIFTED_BIT = NUM_CH - 1;
	localparam logic [NUM_CH-1:0] LATCH_RESET = {NUM_CH{1'b1}};
	localparam logic [NUM_CH-1:0] READ_SHUTDOWN = {NUM_CH{1'b1}};

	typedef struct packed {
		logic              ceN;
		logic              sclk;
		logic              si;
		logic              rstN;
		logic              testMode;
		logic              overTemp;
		logic [NUM_CH-1:0] curLimit;
		logic [NUM_CH-1:0] driverPin;
	} odsc_pins_t;

	localparam int PIN_BITS = $bits(odsc_pins_t);

	// idle pin levels held by the synchronisers in reset, so no false edge follows
	localparam odsc_pins_t PIN_IDLE = '{
		ceN:       1'b1,
		sclk:      1'b0,
		si:        1'b0,
		rstN:      1'b1,
		testMode:  1'b0,
		overTemp:  1'b0,
		curLimit:  '0,
		driverPin: '1
	};

	typedef enum logic [2:0] {
		ST_SLEEP = 3'b001,
		ST_IDLE  = 3'b010,
		ST_SEL   = 3'b100
	} odsc_state_t;

endpackage

// ==== design/odsc_pair_buffer.sv ====
`timescale 1ns/1ps
module odsc_pair_buffer
	import odsc_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);

	if (WIDTH < 1 || DEPTH != 2) begin : g_bad_cfg
		$error("odsc_pair_buffer: WIDTH >= 1 and DEPTH == 2 required");
	end

	logic [WIDTH-1:0] memQ [DEPTH];
	logic             wrIdxQ;
	logic             rdIdxQ;
	logic [1:0]       countQ;
	logic             doPush;
	logic             doPop;

	assign inReady  = (countQ != 2'(DEPTH));
	assign outValid = (countQ != 2'h0);
	assign outData  = memQ[rdIdxQ];
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	//////////////////////////////////////////////////////////////////////////
	// storage
	always_ff @(posedge ref_clk) begin
		if (doPush)
			memQ[wrIdxQ] <= inData;
	end

	//////////////////////////////////////////////////////////////////////////
	// pointers and fill level
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wrIdxQ <= 1'b0;
			rdIdxQ <= 1'b0;
			countQ <= 2'h0;
		end else begin
			if (doPush)
				wrIdxQ <= ~wrIdxQ;
			if (doPop)
				rdIdxQ <= ~rdIdxQ;
			if (doPush && !doPop)
				countQ <= countQ + 2'h1;
			else if (doPop && !doPush)
				countQ <= countQ - 2'h1;
		end
	end

endmodule

// ==== testbench/odsc_serial_ctrl_checker.sv ====
`timescale 1ns/1ps
module odsc_serial_ctrl_checker
	import odsc_pkg::*;
#(
	parameter int CH            = NUM_CH,
	parameter int RST_PULSE_CYC = MIN_RST_PULSE_CYC,
	parameter int OSC_DIV       = OSC_DIV_CYC,
	parameter int SC_TICKS      = SC_LIMIT_TICKS
) (
	input wire logic          ref_clk,
	input wire logic          sys_rst,
	input wire logic          chipEnableN,
	input wire logic          extRstN,
	input wire logic          testMode1,
	input wire logic          overTemp,
	input wire logic [CH-1:0] currentLimit,
	input wire logic          serOut,
	input wire logic          serOutOeN,
	input wire logic [CH-1:0] driverOff,
	input wire logic          sleepMode
);
	localparam int TOG_MAX = 3 * OSC_DIV;
	localparam int RST_MIN = RST_PULSE_CYC - 8;
	localparam int SC_MAX  = SC_TICKS * OSC_DIV + 16;
	int lowCnt_q;
	int ceLow_q;
	int scCnt_q;
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk) begin
		if (sys_rst || extRstN) lowCnt_q <= 0;
		else if (lowCnt_q < RST_PULSE_CYC + 16) lowCnt_q <= lowCnt_q + 1;
	end
	always_ff @(posedge ref_clk) begin
		if (sys_rst || chipEnableN) ceLow_q <= 0;
		else if (ceLow_q < 63) ceLow_q <= ceLow_q + 1;
	end
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !currentLimit[0] || driverOff[0]) scCnt_q <= 0;
		else scCnt_q <= scCnt_q + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_ce_idle;
		(chipEnableN && !testMode1) [*8];
	endsequence
	sequence s_test_on;
		(testMode1 && !sleepMode) [*8];
	endsequence
	sequence s_quiet;
		(!overTemp && currentLimit == '0 && !sleepMode && ceLow_q > 12) [*8];
	endsequence
	a_idle_no_drive: assert property (s_ce_idle |-> serOutOeN)
		else $error("serial out driven while deselected");
	a_sel_drives: assert property ((!chipEnableN) [*8] |-> !serOutOeN)
		else $error("serial out not driven while selected");
	a_ot_all_off: assert property (overTemp [*6] |-> driverOff == '1)
		else $error("driver on during over-temperature");
	a_sleep_off: assert property (sleepMode |-> driverOff == '1)
		else $error("driver on while asleep");
	a_sleep_so_low: assert property (sleepMode && !serOutOeN |-> !serOut)
		else $error("serial out high in reset");
	a_long_pulse: assert property ($rose(sleepMode) |-> $past(lowCnt_q, 8) > RST_MIN)
		else $error("reset accepted from short pulse");
	a_latch_hold: assert property (s_quiet |-> $stable(driverOff))
		else $error("drivers changed without select rising");
	a_sc_bound: assert property (scCnt_q <= SC_MAX)
		else $error("short circuit not disabled in time");
	a_test_osc: assert property (s_test_on |-> ##[1:TOG_MAX] $changed(serOut))
		else $error("oscillator not shown on serial out");
endmodule

bind odsc_serial_ctrl odsc_serial_ctrl_checker #(
	.CH(CH),
	.RST_PULSE_CYC(RST_PULSE_CYC),
	.OSC_DIV(OSC_DIV),
	.SC_TICKS(SC_TICKS)
) i_chk (
	.ref_clk, .sys_rst, .chipEnableN, .extRstN, .testMode1, .overTemp,
	.currentLimit, .serOut, .serOutOeN, .driverOff, .sleepMode
);

// ==== testbench/odsc_host_model.sv ====
`timescale 1ns/1ps
module odsc_host_model (
	input  wire logic ref_clk,
	output logic      ceN,
	output logic      sclk,
	output logic      si,
	input  wire logic so
);
	initial begin
		ceN  = 1'b1;
		sclk = 1'b0;
		si   = 1'b0;
	end
	task automatic hold_sel(input logic v);
		@(posedge ref_clk);
		ceN <= v;
	endtask
	task automatic frame(input logic [7:0] wr, output logic [7:0] rd);
		@(posedge ref_clk);
		ceN <= 1'b0;
		repeat (12) @(posedge ref_clk);
		for (int i = 7; i >= 0; i--) begin
			si   <= wr[i];
			sclk <= 1'b1;
			repeat (8) @(posedge ref_clk);
			rd[i] = so;
			sclk <= 1'b0;
			repeat (8) @(posedge ref_clk);
		end
		ceN <= 1'b1;
		repeat (16) @(posedge ref_clk);
	endtask
endmodule

// ==== testbench/octal_driver_serial_control_tb_top.sv ====
`timescale 1ns/1ps
module octal_driver_serial_control_tb_top
	import odsc_pkg::*;
;
	localparam int RST_P = 20;
	localparam int OSC_P = 4;
	localparam int SC_P  = 16;
	logic        ref_clk;
	logic        sys_rst;
	logic        chipEnableN;
	logic        shiftClk;
	logic        serIn;
	logic        extRstN;
	logic        testMode1;
	logic        overTemp;
	logic [7:0]  currentLimit;
	logic [7:0]  openLoad;
	logic [7:0]  driverPin;
	logic        serOut;
	logic        serOutOeN;
	logic [7:0]  driverOff;
	logic        sleepMode;
	logic        soLast_q;
	logic        soWire;
	int          checks;
	int          bad_count;
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	assign driverPin = driverOff & ~openLoad;
	always_ff @(posedge ref_clk) if (!serOutOeN) soLast_q <= serOut;
	assign soWire = serOutOeN ? ~soLast_q : serOut;
	odsc_serial_ctrl #(
		.RST_PULSE_CYC(RST_P), .OSC_DIV(OSC_P), .SC_TICKS(SC_P), .TEST_SHIFT(2)
	) i_dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .chipEnableN(chipEnableN), .shiftClk(shiftClk),
		.serIn(serIn), .extRstN(extRstN), .testMode1(testMode1), .overTemp(overTemp),
		.currentLimit(currentLimit), .driverPin(driverPin), .serOut(serOut),
		.serOutOeN(serOutOeN), .driverOff(driverOff), .sleepMode(sleepMode)
	);
	odsc_host_model i_host (
		.ref_clk(ref_clk), .ceN(chipEnableN), .sclk(shiftClk), .si(serIn), .so(soWire)
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wait_off0(output int n);
		n = 0;
		while (driverOff[0] !== 1'b1) begin
			tick(1);
			n++;
			if (n > 400) begin
				bad_count++;
				$display("[ERR] disable wait expected done seen timeout");
				final_report();
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_frames();
		logic [7:0] rd;
		check8("reset drivers", LATCH_RESET, driverOff);
		openLoad <= 8'h80;
		i_host.frame(8'h5a, rd);
		check8("readback", 8'h7f, rd);
		openLoad <= 8'h00;
		tick(12);
		check8("latch", 8'h5a, driverOff);
		check8("oe idle", 8'h01, {7'h0, serOutOeN});
		i_host.frame(8'hfe, rd);
		check8("status", 8'h5a, rd);
	endtask
	task automatic t_short();
		int n;
		logic [7:0] rd;
		tick(12);
		currentLimit <= 8'h01;
		wait_off0(n);
		check8("sc timer", 8'h01, {7'h0, n >= (SC_P - 1) * OSC_P});
		i_host.frame(8'hfe, rd);
		check8("sc status", 8'hff, rd);
		check8("sc reenable", 8'h00, {7'h0, driverOff[0]});
		wait_off0(n);
		check8("sc again", 8'hff, driverOff);
		currentLimit <= 8'h00;
	endtask
	task automatic t_overtemp();
		logic [7:0] rd;
		i_host.frame(8'h00, rd);
		overTemp <= 1'b1;
		tick(10);
		check8("ot off", READ_SHUTDOWN, driverOff);
		i_host.frame(8'h0f, rd);
		check8("ot status", READ_SHUTDOWN, rd);
		overTemp <= 1'b0;
		tick(12);
		check8("ot newer", 8'h0f, driverOff);
		overTemp <= 1'b1;
		tick(20);
		overTemp <= 1'b0;
		tick(12);
		check8("ot restore", 8'h0f, driverOff);
	endtask
	task automatic t_ext_reset();
		extRstN <= 1'b0;
		tick(RST_P / 2);
		extRstN <= 1'b1;
		tick(12);
		check8("short pulse", 8'h0f, driverOff);
		extRstN <= 1'b0;
		tick(RST_P + 12);
		check8("sleep", 8'h01, {7'h0, sleepMode});
		check8("rst off", LATCH_RESET, driverOff);
		i_host.hold_sel(1'b0);
		tick(10);
		check8("rst so sel", 8'h00, {6'h0, serOutOeN, serOut});
		i_host.hold_sel(1'b1);
		tick(10);
		check8("rst so idle", 8'h02, {6'h0, serOutOeN, serOut});
		extRstN <= 1'b1;
		tick(12);
		check8("wake", 8'h00, {7'h0, sleepMode});
	endtask
	task automatic t_test_mode();
		int n;
		logic v;
		logic [7:0] rd;
		i_host.frame(8'hfe, rd);
		check8("wake status", 8'hff, rd);
		testMode1 <= 1'b1;
		currentLimit <= 8'h01;
		wait_off0(n);
		check8("sc short", 8'h01, {7'h0, n < (SC_P - 1) * OSC_P});
		currentLimit <= 8'h00;
		i_host.hold_sel(1'b0);
		tick(10);
		for (int k = 0; k < 2; k++) begin
			v = serOut;
			n = 0;
			while (serOut === v && n < 3 * OSC_P) begin
				tick(1);
				n++;
			end
			check8("osc toggle", 8'h01, {7'h0, serOut !== v});
		end
		testMode1 <= 1'b0;
		i_host.hold_sel(1'b1);
		tick(10);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst      = 1'b1;
		extRstN      = 1'b1;
		testMode1    = 1'b0;
		overTemp     = 1'b0;
		currentLimit = 8'h00;
		openLoad     = 8'h00;
		checks       = 0;
		bad_count    = 0;
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		tick(8);
		t_frames();
		t_short();
		t_overtemp();
		t_ext_reset();
		t_test_mode();
		final_report();
	end
endmodule
